// [core/timer_params.svh]
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define REG_CONFIG 8'h00
`define REG_COMMAND 8'h04
`define REG_DURATION 8'h08
`define REG_REMAINING 8'h0c
`define REG_ELAPSED 8'h10
`define REG_SP1 8'h14
`define REG_SP2 8'h18
`define REG_THRESHOLD 8'h1c
`define REG_RAMP_RATE 8'h20
`define REG_SOFT_LIMIT 8'h24
`define REG_SOFT_THRESHOLD 8'h28
`define REG_WORKING_SP 8'h2c
`define REG_POWER 8'h30

`define CFG_TYPE_LSB 0
`define CFG_RES_BIT 2
`define CFG_END_LSB 4
`define CFG_OUT4_BIT 6
`define CFG_RAMP_EN_BIT 7
`define CFG_THR_OFF_BIT 8
`define CFG_DI1_LSB 12
`define CFG_DI2_LSB 16

`define CONFIG_RESET 32'h0000_0000
`define DURATION_RESET 32'h0000_0001
`define SP1_RESET 16'h0064
`define SP2_RESET 16'h0032
`define THRESHOLD_RESET 16'h000a
`define RAMP_RATE_RESET 16'h0001
`define SOFT_LIMIT_RESET 8'h14
`define SOFT_THRESHOLD_RESET 16'h0032
`define POWER_MAX 8'h64
`define POWER_RISE_STEP 8'h05

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define CLK_PERIOD_NS 10
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define MINUTE_SECONDS 60
`define HOUR_SECONDS 3600

`endif

// [core/timer_pkg.sv]
package timer_pkg;
  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_HOLD, ST_END} status_e;
  typedef enum logic [1:0] {TYPE_DWELL, TYPE_DELAY, TYPE_SOFT} type_e;
  typedef enum logic [1:0] {END_OFF, END_SP2, END_DWELL, END_RESET} end_e;
  typedef enum logic [1:0] {CMD_RESET, CMD_RUN, CMD_HOLD, CMD_NONE} cmd_e;
  typedef enum logic [2:0] {DI_NONE, DI_RUN, DI_RESET, DI_HOLD, DI_LEVEL}
    di_e;
endpackage : timer_pkg

// [core/time_base.sv]
`include "timer_params.svh"

module time_base #(
  parameter int SECOND_CYCLES = `SECOND_CYCLES,
  parameter int MINUTE_SECONDS = `MINUTE_SECONDS,
  parameter int HOUR_SECONDS = `HOUR_SECONDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic enable,
  input wire logic hours_select,
  output logic second_pulse,
  output logic tick
);
  logic [31:0] cycle_reg;
  logic [11:0] sec_reg;
  logic [11:0] sec_limit;

  // The resolution setting picks the seconds per counting tick.
  assign sec_limit = hours_select ? 12'(HOUR_SECONDS - 1)
                                  : 12'(MINUTE_SECONDS - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_reg <= 32'h0000_0000;
      second_pulse <= 1'b0;
    end else if (ce) begin
      second_pulse <= (cycle_reg == 32'(SECOND_CYCLES - 1));
      if (cycle_reg == 32'(SECOND_CYCLES - 1)) begin
        cycle_reg <= 32'h0000_0000;
      end else begin
        cycle_reg <= cycle_reg + 32'h0000_0001;
      end
    end
  end

  // One tick per period while counting; a restart aligns the period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_reg <= 12'h000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        sec_reg <= 12'h000;
      end else if (enable && cycle_reg == 32'(SECOND_CYCLES - 1)) begin
        if (sec_reg == sec_limit) begin
          sec_reg <= 12'h000;
          tick <= 1'b1;
        end else begin
          sec_reg <= sec_reg + 12'h001;
        end
      end
    end
  end
endmodule : time_base

// [core/process_timer_sequencer.sv]
// Overview of operation
// - Three timer behaviours selected by configuration.
// - Resolution setting sets the counting time base.
// - Dwell run loads setpoint from process value.
// - Dwell ramp moves setpoint toward primary setpoint.
// - Dwell counting waits for deviation band.
// - Counting continues once started despite band.
// - End action off forces standby, zero power.
// - End action two ramps to secondary, then end.
// - End action dwell keeps regulating at setpoint.
// - End action reset restores primary setpoint.
// - Writing remaining time adjusts running period.
// - Elapsed counts up, remaining counts down.
// - Remaining write after end reruns on primary.
// - No counting while status is reset.
// - Hold freezes timer and control condition.
// - Power-up enters run sequence automatically.
// - Output four follows run/hold or end.
// - Digital inputs force run, reset, hold, level.
// - Delayed switch-on keeps outputs off while timing.
// - Delayed switch-on end raises power gradually.
// - Hold during delayed switch-on keeps outputs off.
// - Soft start clamps power, ends at threshold.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`include "timer_params.svh"

module process_timer_sequencer #(
  parameter int PV_W = 16,
  parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [PV_W-1:0] process_value,
  input wire logic [7:0] demand_power,
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  output logic [PV_W-1:0] working_setpoint,
  output logic [7:0] output_power,
  output logic standby,
  output logic output_four,
  output timer_pkg::status_e timer_status
);
  import timer_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [PV_W-1:0] absdiff(input logic [PV_W-1:0] a,
                                              input logic [PV_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic logic [PV_W-1:0] step_to(input logic [PV_W-1:0] cur,
                                              input logic [PV_W-1:0] tgt,
                                              input logic [PV_W-1:0] rate);
    logic [PV_W-1:0] res;
    res = tgt;
    if (absdiff(cur, tgt) > rate) begin
      res = (cur < tgt) ? cur + rate : cur - rate;
    end
    return res;
  endfunction : step_to

  function automatic logic [7:0] lesser(input logic [7:0] a,
                                        input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction : lesser

  function automatic cmd_e di_req(input logic [2:0] func, input logic lvl);
    cmd_e res;
    res = CMD_NONE;
    case (func)
      DI_RUN: res = lvl ? CMD_RUN : CMD_NONE;
      DI_RESET: res = lvl ? CMD_RESET : CMD_NONE;
      DI_HOLD: res = lvl ? CMD_HOLD : CMD_NONE;
      DI_LEVEL: res = lvl ? CMD_RUN : CMD_RESET;
      default: res = CMD_NONE;
    endcase
    return res;
  endfunction : di_req

  logic [31:0] cfg_reg, duration_reg, elapsed_reg, remaining_reg;
  logic [PV_W-1:0] sp1_reg, sp2_reg, thr_reg, ramp_reg, soft_thr_reg;
  logic [7:0] soft_limit_reg, ceiling_reg, power_next;
  logic aw_held_reg, w_held_reg, rd_hit;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rd_data;
  logic [3:0] w_strb_reg;
  logic wr_fire, cmd_wr, rem_wr, wr_hit;
  logic [1:0] di_meta_reg, di_sync_reg;
  logic start_pend_reg, hold_by_di_reg, counting_reg, timed_out_reg;
  logic sp2_sel_reg, second_pulse, tick, in_band, gate_ok, complete;
  logic do_start, do_resume, do_rerun, do_hold, do_reset, off_end;
  cmd_e di_cmd, req;
  type_e type_sel;
  end_e end_sel;
  logic [PV_W-1:0] target_sp;

  // AXI4-Lite write path: address and data are taken in either order.
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
  assign cmd_wr = wr_fire && aw_addr_reg == `REG_COMMAND && w_strb_reg[0];
  assign rem_wr = wr_fire && aw_addr_reg == `REG_REMAINING;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_reg)
      `REG_CONFIG, `REG_COMMAND, `REG_DURATION, `REG_REMAINING, `REG_SP1,
      `REG_SP2, `REG_THRESHOLD, `REG_RAMP_RATE, `REG_SOFT_LIMIT,
      `REG_SOFT_THRESHOLD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `CONFIG_RESET;
      duration_reg <= `DURATION_RESET;
      sp1_reg <= PV_W'(`SP1_RESET);
      sp2_reg <= PV_W'(`SP2_RESET);
      thr_reg <= PV_W'(`THRESHOLD_RESET);
      ramp_reg <= PV_W'(`RAMP_RATE_RESET);
      soft_limit_reg <= `SOFT_LIMIT_RESET;
      soft_thr_reg <= PV_W'(`SOFT_THRESHOLD_RESET);
    end else if (ce && wr_fire) begin
      case (aw_addr_reg)
        `REG_CONFIG: cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg);
        `REG_DURATION:
          duration_reg <= merge(duration_reg, w_data_reg, w_strb_reg);
        `REG_SP1: sp1_reg <= PV_W'(merge(32'(sp1_reg), w_data_reg,
                                         w_strb_reg));
        `REG_SP2: sp2_reg <= PV_W'(merge(32'(sp2_reg), w_data_reg,
                                         w_strb_reg));
        `REG_THRESHOLD: thr_reg <= PV_W'(merge(32'(thr_reg), w_data_reg,
                                               w_strb_reg));
        `REG_RAMP_RATE: ramp_reg <= PV_W'(merge(32'(ramp_reg), w_data_reg,
                                                w_strb_reg));
        `REG_SOFT_LIMIT: soft_limit_reg <= 8'(merge(32'(soft_limit_reg),
                                                 w_data_reg, w_strb_reg));
        `REG_SOFT_THRESHOLD: soft_thr_reg <= PV_W'(merge(32'(soft_thr_reg),
                                                 w_data_reg, w_strb_reg));
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path.
  assign arready = !rvalid;

  always_comb begin
    rd_hit = 1'b1;
    case ({araddr[7:2], 2'b00})
      `REG_CONFIG: rd_data = cfg_reg;
      `REG_COMMAND: rd_data = {28'h0000000, sp2_sel_reg, counting_reg,
                               timer_status};
      `REG_DURATION: rd_data = duration_reg;
      `REG_REMAINING: rd_data = remaining_reg;
      `REG_ELAPSED: rd_data = elapsed_reg;
      `REG_SP1: rd_data = 32'(sp1_reg);
      `REG_SP2: rd_data = 32'(sp2_reg);
      `REG_THRESHOLD: rd_data = 32'(thr_reg);
      `REG_RAMP_RATE: rd_data = 32'(ramp_reg);
      `REG_SOFT_LIMIT: rd_data = 32'(soft_limit_reg);
      `REG_SOFT_THRESHOLD: rd_data = 32'(soft_thr_reg);
      `REG_WORKING_SP: rd_data = 32'(working_setpoint);
      `REG_POWER: rd_data = 32'(output_power);
      default: begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Remote switches pass two flip-flops before use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      di_meta_reg <= 2'b00;
      di_sync_reg <= 2'b00;
    end else if (ce) begin
      di_meta_reg <= {digital_input_two, digital_input_one};
      di_sync_reg <= di_meta_reg;
    end
  end

  always_comb begin
    cmd_e a, b;
    a = di_req(cfg_reg[`CFG_DI1_LSB +: 3], di_sync_reg[0]);
    b = di_req(cfg_reg[`CFG_DI2_LSB +: 3], di_sync_reg[1]);
    if (a == CMD_HOLD || b == CMD_HOLD) begin
      di_cmd = CMD_HOLD;
    end else if (a == CMD_RESET || b == CMD_RESET) begin
      di_cmd = CMD_RESET;
    end else if (a == CMD_RUN || b == CMD_RUN) begin
      di_cmd = CMD_RUN;
    end else begin
      di_cmd = CMD_NONE;
    end
  end

  assign req = (di_cmd != CMD_NONE) ? di_cmd
             : cmd_wr ? cmd_e'(w_data_reg[1:0]) : CMD_NONE;

  always_comb begin
    case (cfg_reg[`CFG_TYPE_LSB +: 2])
      2'h1: type_sel = TYPE_DELAY;
      2'h2: type_sel = TYPE_SOFT;
      default: type_sel = TYPE_DWELL;
    endcase
  end

  assign end_sel = end_e'(cfg_reg[`CFG_END_LSB +: 2]);
  assign target_sp = sp2_sel_reg ? sp2_reg : sp1_reg;
  assign in_band = cfg_reg[`CFG_THR_OFF_BIT]
                || absdiff(process_value, target_sp) <= thr_reg;
  assign gate_ok = type_sel != TYPE_DWELL || in_band || counting_reg;
  assign complete = timer_status == ST_RUN && !timed_out_reg
                 && ((counting_reg && remaining_reg == 32'h0000_0000)
                 || (type_sel == TYPE_SOFT
                     && process_value >= soft_thr_reg));

  assign do_reset = req == CMD_RESET && timer_status != ST_RESET;
  assign do_hold = req == CMD_HOLD && timer_status == ST_RUN;
  assign do_start = start_pend_reg || (req == CMD_RUN
                 && (timer_status == ST_RESET || timer_status == ST_END));
  assign do_resume = timer_status == ST_HOLD && (req == CMD_RUN
                  || (hold_by_di_reg && di_cmd == CMD_NONE));
  assign do_rerun = rem_wr && timer_status == ST_END;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_status <= ST_RUN;
      start_pend_reg <= 1'b1;
      hold_by_di_reg <= 1'b0;
    end else if (ce) begin
      start_pend_reg <= 1'b0;
      if (do_reset) begin
        timer_status <= ST_RESET;
        hold_by_di_reg <= 1'b0;
      end else if (do_hold) begin
        timer_status <= ST_HOLD;
        hold_by_di_reg <= di_cmd == CMD_HOLD;
      end else if (do_start || do_resume || do_rerun) begin
        timer_status <= ST_RUN;
      end else if (complete) begin
        if (type_sel == TYPE_DWELL && end_sel == END_RESET) begin
          timer_status <= ST_RESET;
        end else if (type_sel != TYPE_DWELL || end_sel != END_SP2) begin
          timer_status <= ST_END;
        end
      end else if (timer_status == ST_RUN && timed_out_reg
                   && working_setpoint == sp2_reg) begin
        timer_status <= ST_END;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_reg <= 32'h0000_0000;
      remaining_reg <= `DURATION_RESET;
      counting_reg <= 1'b0;
      timed_out_reg <= 1'b0;
    end else if (ce) begin
      if (do_reset) begin
        counting_reg <= 1'b0;
      end else if (do_start) begin
        elapsed_reg <= 32'h0000_0000;
        remaining_reg <= duration_reg;
        counting_reg <= 1'b0;
        timed_out_reg <= 1'b0;
      end else if (do_rerun) begin
        elapsed_reg <= 32'h0000_0000;
        remaining_reg <= w_data_reg;
        counting_reg <= 1'b0;
        timed_out_reg <= 1'b0;
      end else if (rem_wr && timer_status == ST_RUN) begin
        remaining_reg <= merge(remaining_reg, w_data_reg, w_strb_reg);
      end else if (timer_status == ST_RUN && !timed_out_reg) begin
        if (complete) begin
          timed_out_reg <= 1'b1;
          counting_reg <= 1'b0;
        end else begin
          counting_reg <= gate_ok;
          if (counting_reg && tick) begin
            elapsed_reg <= elapsed_reg + 32'h0000_0001;
            remaining_reg <= remaining_reg - 32'h0000_0001;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp2_sel_reg <= 1'b0;
    end else if (ce) begin
      if (do_start || do_rerun || do_reset) begin
        sp2_sel_reg <= 1'b0;
      end else if (complete && type_sel == TYPE_DWELL) begin
        sp2_sel_reg <= end_sel == END_SP2;
      end
    end
  end

  time_base #(.SECOND_CYCLES(SECOND_CYCLES)) u_time_base (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .restart(do_start || do_rerun || do_reset),
    .enable(counting_reg && timer_status == ST_RUN),
    .hours_select(cfg_reg[`CFG_RES_BIT]),
    .second_pulse(second_pulse),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_setpoint <= PV_W'(`SP1_RESET);
    end else if (ce) begin
      if (type_sel != TYPE_DWELL) begin
        working_setpoint <= target_sp;
      end else if (do_start) begin
        working_setpoint <= process_value;
      end else if (timer_status == ST_RESET) begin
        working_setpoint <= sp1_reg;
      end else if (timer_status != ST_HOLD) begin
        if (!cfg_reg[`CFG_RAMP_EN_BIT]) begin
          working_setpoint <= target_sp;
        end else if (second_pulse) begin
          working_setpoint <= step_to(working_setpoint, target_sp,
                                      ramp_reg);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ceiling_reg <= `POWER_MAX;
    end else if (ce) begin
      if (type_sel == TYPE_DELAY
          && (timer_status == ST_RUN || timer_status == ST_HOLD)) begin
        ceiling_reg <= 8'h00;
      end else if (second_pulse && ceiling_reg < `POWER_MAX) begin
        ceiling_reg <= lesser(ceiling_reg + `POWER_RISE_STEP,
                              `POWER_MAX);
      end
    end
  end

  assign off_end = (type_sel == TYPE_DWELL && end_sel == END_OFF
                    && timer_status == ST_END)
                || (type_sel == TYPE_DELAY && (timer_status == ST_RUN
                    || timer_status == ST_HOLD));

  always_comb begin
    if (off_end) begin
      power_next = 8'h00;
    end else if (type_sel == TYPE_SOFT && (timer_status == ST_RUN
                 || timer_status == ST_HOLD)) begin
      power_next = lesser(demand_power, soft_limit_reg);
    end else begin
      power_next = lesser(demand_power, ceiling_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_power <= 8'h00;
      standby <= 1'b0;
      output_four <= 1'b0;
    end else if (ce) begin
      output_power <= power_next;
      standby <= off_end;
      output_four <= cfg_reg[`CFG_OUT4_BIT] ? timer_status == ST_END
                   : (timer_status == ST_RUN
                      || timer_status == ST_HOLD);
    end
  end
endmodule : process_timer_sequencer

// [verif/timer_checker_sva.sv]
module timer_checker #(
  parameter int PV_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic standby,
  input wire logic [7:0] output_power,
  input wire logic [PV_W-1:0] working_setpoint,
  input wire timer_pkg::status_e timer_status
);
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready && ce;
  endsequence
  sequence s_held_twice;
    (timer_status == ST_HOLD) [*2];
  endsequence
  a_standby_zero: assert property (
    standby |-> output_power == 8'h00) else $error("Power in standby.");
  a_powerup_run: assert property (
    $rose(aresetn) |-> timer_status == ST_RUN && output_power == 8'h00)
    else $error("No run after reset.");
  a_hold_frozen: assert property (
    s_held_twice |-> $stable(working_setpoint))
    else $error("Setpoint moved in hold.");
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("Write answer late.");
  a_read_answer: assert property (arvalid && arready && ce |=> rvalid)
    else $error("Read answer late.");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write answer dropped.");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read answer dropped.");
  a_wr_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("Write taken during answer.");
  a_rd_refuse: assert property (rvalid |-> !arready)
    else $error("Read taken during answer.");
endmodule : timer_checker

bind process_timer_sequencer timer_checker #(.PV_W(PV_W)) chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .standby(standby),
  .output_power(output_power), .working_setpoint(working_setpoint),
  .timer_status(timer_status));

// [verif/plant_model.sv]
module plant_model (
  input wire logic aclk,
  input wire logic [15:0] pv_goal,
  input wire logic [1:0] di_req,
  output logic [15:0] process_value = 16'h0000,
  output logic [7:0] demand_power = 8'h64,
  output logic digital_input_one = 1'h0,
  output logic digital_input_two = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // The process drifts one unit per cycle toward its goal.
  always @(posedge aclk) begin
    if (process_value < pv_goal) begin
      process_value <= process_value + 16'h0001;
    end else if (process_value > pv_goal) begin
      process_value <= process_value - 16'h0001;
    end
    digital_input_one <= di_req[0];
    digital_input_two <= di_req[1];
  end
endmodule : plant_model

// [verif/tb_top.sv]
`include "timer_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, demand_power, output_power;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, d1, d2;
  logic awready, wready, bvalid, arready, rvalid, standby, output_four;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, di_req = 2'h0;
  logic [15:0] process_value, working_setpoint, pv_goal = 16'h0064;
  status_e timer_status;
  int bad_count = 0, checks = 0;

  process_timer_sequencer #(.SECOND_CYCLES(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .process_value(process_value), .demand_power(demand_power),
    .digital_input_one(d1), .digital_input_two(d2),
    .working_setpoint(working_setpoint), .output_power(output_power),
    .standby(standby), .output_four(output_four),
    .timer_status(timer_status));
  plant_model plant (
    .aclk(aclk), .pv_goal(pv_goal), .di_req(di_req),
    .process_value(process_value), .demand_power(demand_power),
    .digital_input_one(d1), .digital_input_two(d2));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_d, w_d;
    aw_d = 1'h0;
    w_d = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      aw_d = aw_d | awready;
      w_d = w_d | wready;
      awvalid <= !aw_d;
      wvalid <= !w_d;
    end
    cyc(3);
    bready <= 1'h1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    check(32'(bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    cyc(2);
    rready <= 1'h1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    check(rdata, exp);
  endtask : rd

  task automatic cmd(input cmd_e c);
    wr(`REG_COMMAND, 32'(c), `RESP_OKAY);
  endtask : cmd

  task automatic wait_st(input status_e s, input int n);
    for (int i = 0; i < n && timer_status !== s; i++) begin
      @(posedge aclk);
    end
    check(32'(timer_status), 32'(s));
  endtask : wait_st

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    #100us;
    bad_count++;
    results();
  end

  initial begin
    cyc(6);
    aresetn <= 1'h1;
    cyc(1);
    check(32'(timer_status), 32'(ST_RUN));
    rd(`REG_SP1, 32'h64);
    rd(`REG_DURATION, 32'h1);
    rd(8'h40, 32'h0);
    check(32'(rresp), 32'(`RESP_SLVERR));
    wr(`REG_ELAPSED, 32'h5, `RESP_SLVERR);
    $display("reset test done");
    wr(`REG_CONFIG, 32'h80, `RESP_OKAY);
    cmd(CMD_RESET);
    check(32'(output_four), 32'h0);
    cyc(300);
    rd(`REG_ELAPSED, 32'h0);
    pv_goal <= 16'h0020;
    cyc(100);
    cmd(CMD_RUN);
    check(32'(working_setpoint <= 16'h22), 32'h1);
    cyc(500);
    check(32'(working_setpoint), 32'h64);
    rd(`REG_ELAPSED, 32'h0);
    check(32'(output_four), 32'h1);
    pv_goal <= 16'h0064;
    cyc(100);
    cmd(CMD_HOLD);
    check(32'(timer_status), 32'(ST_HOLD));
    cyc(400);
    rd(`REG_REMAINING, 32'h1);
    cmd(CMD_RUN);
    pv_goal <= 16'h0020;
    wait_st(ST_END, 400);
    cyc(1);
    check(32'(standby), 32'h1);
    rd(`REG_ELAPSED, 32'h1);
    rd(`REG_REMAINING, 32'h0);
    pv_goal <= 16'h0064;
    $display("dwell test done");
    cmd(CMD_RESET);
    wr(`REG_CONFIG, 32'h10, `RESP_OKAY);
    cmd(CMD_RUN);
    wait_st(ST_END, 400);
    check(32'(working_setpoint), 32'h32);
    wr(`REG_REMAINING, 32'h1, `RESP_OKAY);
    check(32'(timer_status), 32'(ST_RUN));
    check(32'(working_setpoint), 32'h64);
    $display("second setpoint test done");
    cmd(CMD_RESET);
    wr(`REG_CONFIG, 32'h01, `RESP_OKAY);
    cmd(CMD_RUN);
    cyc(20);
    check(32'(standby), 32'h1);
    cmd(CMD_HOLD);
    check(32'(standby), 32'h1);
    cmd(CMD_RUN);
    wait_st(ST_END, 400);
    cyc(2);
    check(32'(output_power < 8'h64), 32'h1);
    cyc(120);
    check(32'(output_power), 32'h64);
    $display("delay test done");
    wr(`REG_CONFIG, 32'h02, `RESP_OKAY);
    pv_goal <= 16'h0010;
    cmd(CMD_RESET);
    cyc(100);
    cmd(CMD_RUN);
    cyc(20);
    check(32'(output_power), 32'h14);
    pv_goal <= 16'h0040;
    wait_st(ST_END, 100);
    $display("soft start test done");
    wr(`REG_CONFIG, 32'h160, `RESP_OKAY);
    cmd(CMD_RUN);
    wr(`REG_REMAINING, 32'h2, `RESP_OKAY);
    rd(`REG_REMAINING, 32'h2);
    wait_st(ST_END, 600);
    cyc(1);
    check(32'(standby), 32'h0);
    check(32'(output_four), 32'h1);
    check(32'(working_setpoint), 32'h64);
    wr(`REG_CONFIG, 32'h130, `RESP_OKAY);
    cmd(CMD_RUN);
    wait_st(ST_RESET, 400);
    rd(`REG_COMMAND, 32'h0);
    wr(`REG_CONFIG, 32'h104, `RESP_OKAY);
    cmd(CMD_RUN);
    cyc(300);
    rd(`REG_ELAPSED, 32'h0);
    $display("end action test done");
    wr(`REG_CONFIG, 32'h0004_3000, `RESP_OKAY);
    wait_st(ST_RESET, 10);
    di_req <= 2'h2;
    wait_st(ST_RUN, 10);
    di_req <= 2'h3;
    wait_st(ST_HOLD, 10);
    di_req <= 2'h2;
    wait_st(ST_RUN, 10);
    di_req <= 2'h0;
    wait_st(ST_RESET, 10);
    ce <= 1'h0;
    di_req <= 2'h2;
    cyc(10);
    check(32'(timer_status), 32'(ST_RESET));
    ce <= 1'h1;
    wait_st(ST_RUN, 10);
    $display("input test done");
    results();
  end
endmodule : tb_top
